// ### sswr_pkg.sv
/*
 * constants, state codes and pin carrier for the supply supervisor
 * assumes one 50 MHz clock; all times become cycle counts here
 */
package sswr_pkg;

    // ----------------------------------------------------------------
    // clock and times
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned CLK_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
    // reset_hold_period: 140 min, 200 typ, 400 max (ms); typ chosen
    localparam int unsigned HOLD_MS      = 200;
    // watchdog_period: 1120 min, 1600 typ, 3200 max (ms); typ chosen
    localparam int unsigned WD_MS        = 1600;
    // manual input filter; rejects ~100 ns, passes 1 us pulses
    localparam int unsigned DEB_NS       = 500;
    localparam int unsigned HOLD_CYC     = HOLD_MS * CLK_PER_MS;
    localparam int unsigned WD_CYC       = WD_MS * CLK_PER_MS;
    localparam int unsigned DEB_CYC      = (DEB_NS * CLK_PER_US + 999) / 1000;
    // pull pattern: low for 7/8 of the period, high for the last 1/8
    localparam int unsigned PULL_DEN     = 8;
    // cycles a pin change takes to reach the filtered level, with margin
    localparam int unsigned SYNC_LAG     = 8;

    // ----------------------------------------------------------------
    // widths and reset values
    // ----------------------------------------------------------------
    localparam int unsigned CNT_W        = 27;
    localparam int unsigned DEB_W        = 5;

    typedef enum logic [2:0] {
        ST_SRC  = 3'h1,
        ST_HOLD = 3'h2,
        ST_RUN  = 3'h4
    } sswr_state_e;

    typedef struct packed {
        logic uv;
        logic mr_n;
        logic stb;
    } sswr_pin_s;

    // undervoltage assumed and manual reset released at reset
    localparam sswr_pin_s PIN_RST        = 3'h6;
    localparam sswr_state_e STATE_RST    = ST_SRC;

endpackage : sswr_pkg

// ### sswr_proc_model.sv
/*
 * processor-side model: drives the watchdog strobe pin or floats it
 * assumes the supervisor clock and its weak pull output and enable
 */
`timescale 1ns/10ps
module sswr_proc_model
    import sswr_pkg::*;
#(
    parameter int unsigned PER = 100
) (
    input  wire logic clk_i,
    input  wire logic serve_i,
    input  wire logic drive_i,
    input  wire logic pull_i,
    input  wire logic pull_oe_i,
    output logic      pin_o
);
    // ------------------------------------------------------------
    // strobe driver
    // ------------------------------------------------------------
    logic [15:0] cnt_r = 16'h0000;
    logic        drv_r = 1'b0;
    // held low most of the time, short high pulse to service
    always_ff @(posedge clk_i) begin
        cnt_r <= (cnt_r >= 16'(PER - 1)) ? 16'h0000 : cnt_r + 16'h0001;
        drv_r <= serve_i && (cnt_r < 16'h0004);
    end
    // strong driver beats the weak pull; no pull at all reads inverted
    assign pin_o = drive_i ? drv_r : (pull_oe_i ? pull_i : ~drv_r);
endmodule : sswr_proc_model

// ### sswr_top.sv
/*
 * supply supervisor: undervoltage, manual reset and watchdog drive
 * both reset outputs, with a held release and open-strobe pulling.
 * assumes the comparator result, manual reset and strobe pins are
 * asynchronous; the strobe pull is weak and any external driver wins.
 */
// Function
// (RULE1) undervoltage asserts reset while it lasts
// (RULE2) power-up reset held after supply recovers
// (RULE3) low manual input asserts reset
// (RULE4) manual input debounced, reset at least hold
// (RULE5) manual hold starts when input released
// (RULE6) manual low reaches reset within 5 us
// (RULE7) short manual glitches ignored, 1 us works
// (RULE8) no strobe edge for period forces reset
// (RULE9) watchdog counts only while reset inactive
// (RULE10) any strobe edge restarts watchdog period
// (RULE11) timeout gives hold reset, then restarts
// (RULE12) open strobe pulled low 7/8, high 1/8
// (RULE13) pull pattern repeats every watchdog period
// (RULE14) open strobe services watchdog internally
// (RULE15) controller keeps strobe low, pulses high
// (RULE16) hold period lies between 140 and 400 ms
// (RULE17) high reset is complement of low reset
`timescale 1ns/10ps
module sswr_top
    import sswr_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = HOLD_CYC,
    parameter int unsigned WD_CYCLES   = WD_CYC
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic undervolt_i,
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_strobe_in_i,
    output logic      watchdog_strobe_out_o,
    output logic      watchdog_strobe_oe_o,
    output logic      strobe_open_o,
    output logic      reset_n_o,
    output logic      reset_o
);

    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WD_LAST   = CNT_W'(WD_CYCLES - 1);
    localparam logic [CNT_W-1:0] PULL_HI   = CNT_W'(WD_CYCLES - WD_CYCLES / PULL_DEN);
    localparam logic [DEB_W-1:0] DEB_LAST  = DEB_W'(DEB_CYC - 1);
    localparam logic [CNT_W-1:0] SELF_WIN  = CNT_W'(SYNC_LAG);
    localparam logic [CNT_W-1:0] SELF_HI   = CNT_W'(PULL_HI + SYNC_LAG);

    // ----------------------------------------------------------------
    // pin synchronisers: three stages, a change counts once 2 and 3 agree
    // ----------------------------------------------------------------
    sswr_pin_s s1_r, s2_r, s3_r, lvl_r;
    sswr_pin_s pins, lvl_nxt;
    logic      stb_edge;

    always_comb begin
        pins.uv   = undervolt_i;
        pins.mr_n = manual_reset_n_i;
        pins.stb  = watchdog_strobe_in_i;
        lvl_nxt   = lvl_r;
        if (s2_r.uv == s3_r.uv) begin
            lvl_nxt.uv = s3_r.uv;
        end
        if (s2_r.mr_n == s3_r.mr_n) begin
            lvl_nxt.mr_n = s3_r.mr_n;
        end
        if (s2_r.stb == s3_r.stb) begin
            lvl_nxt.stb = s3_r.stb;
        end
        stb_edge = (lvl_nxt.stb != lvl_r.stb);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r  <= PIN_RST;
            s2_r  <= PIN_RST;
            s3_r  <= PIN_RST;
            lvl_r <= PIN_RST;
        end else begin
            s1_r  <= pins;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // manual reset filter
    // ----------------------------------------------------------------
    // a low must stand DEB_CYC cycles: 100 ns glitches die, 1 us passes
    logic             mr_deb_r, mr_deb_nxt;
    logic [DEB_W-1:0] deb_cnt_r, deb_cnt_nxt;

    always_comb begin
        mr_deb_nxt  = mr_deb_r;
        deb_cnt_nxt = '0;
        if (lvl_r.mr_n != mr_deb_r) begin
            if (deb_cnt_r == DEB_LAST) begin
                mr_deb_nxt = lvl_r.mr_n; // RULE4 RULE6 RULE7
            end else begin
                deb_cnt_nxt = deb_cnt_r + DEB_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mr_deb_r  <= 1'b1;
            deb_cnt_r <= '0;
        end else begin
            mr_deb_r  <= mr_deb_nxt;
            deb_cnt_r <= deb_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer and watchdog
    // ----------------------------------------------------------------
    sswr_state_e      state_r, state_nxt;
    logic [CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
    logic [CNT_W-1:0] wd_cnt_r, wd_cnt_nxt;
    logic             rst_r, rst_nxt;
    logic             src_active;

    always_comb begin
        src_active   = lvl_r.uv || !mr_deb_r; // RULE1 RULE3
        state_nxt    = state_r;
        hold_cnt_nxt = '0;
        wd_cnt_nxt   = '0;
        unique case (state_r)
            ST_SRC: begin
                // hold counts from source release, not from its onset
                if (!src_active) begin
                    state_nxt = ST_HOLD; // RULE2 RULE5
                end
            end
            ST_HOLD: begin
                if (hold_cnt_r == HOLD_LAST) begin
                    state_nxt = ST_RUN; // RULE16
                end else begin
                    hold_cnt_nxt = hold_cnt_r + CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (stb_edge) begin
                    wd_cnt_nxt = '0; // RULE10 RULE14
                end else if (wd_cnt_r == WD_LAST) begin
                    state_nxt = ST_HOLD; // RULE8 RULE11
                end else begin
                    wd_cnt_nxt = wd_cnt_r + CNT_W'(1); // RULE9
                end
            end
        endcase
        if (src_active) begin
            state_nxt    = ST_SRC; // RULE1
            hold_cnt_nxt = '0;
            wd_cnt_nxt   = '0;
        end
        rst_nxt = (state_nxt != ST_RUN);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r    <= STATE_RST;
            hold_cnt_r <= '0;
            wd_cnt_r   <= '0;
            rst_r      <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            wd_cnt_r   <= wd_cnt_nxt;
            rst_r      <= rst_nxt;
        end
    end

    assign reset_o   = rst_r;
    assign reset_n_o = !rst_r; // RULE17

    // ----------------------------------------------------------------
    // open-strobe pull pattern and detection
    // ----------------------------------------------------------------
    // the pull's own edges service the watchdog when nobody drives
    logic [CNT_W-1:0] pull_cnt_r, pull_cnt_nxt;
    logic             pull_hi_r, pull_hi_nxt;
    logic             low_seen_r, low_seen_nxt;
    logic             open_r, open_nxt;
    // the pull's own edges return through the synchroniser a few cycles late;
    // only a foreign edge restarts the pattern, so it stays locked to the
    // watchdog period and a pin that is let go is still serviced in time
    logic             pull_self;

    always_comb begin
        pull_self    = (lvl_nxt.stb == pull_hi_r)
                       && ((pull_cnt_r >= PULL_HI && pull_cnt_r < SELF_HI)
                           || pull_cnt_r < SELF_WIN);
        pull_cnt_nxt = '0;
        low_seen_nxt = low_seen_r;
        open_nxt     = open_r;
        if (!rst_r) begin
            if (stb_edge && !pull_self) begin
                pull_cnt_nxt = '0; // RULE12 RULE14
            end else if (pull_cnt_r != WD_LAST) begin
                pull_cnt_nxt = pull_cnt_r + CNT_W'(1); // RULE13
            end
            if (pull_cnt_nxt == PULL_HI) begin
                low_seen_nxt = !lvl_r.stb;
            end
            if (pull_cnt_r == WD_LAST) begin
                open_nxt = low_seen_r && lvl_r.stb;
            end
        end
        pull_hi_nxt = (pull_cnt_nxt >= PULL_HI); // RULE12
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pull_cnt_r <= '0;
            pull_hi_r  <= 1'b0;
            low_seen_r <= 1'b0;
            open_r     <= 1'b0;
        end else begin
            pull_cnt_r <= pull_cnt_nxt;
            pull_hi_r  <= pull_hi_nxt;
            low_seen_r <= low_seen_nxt;
            open_r     <= open_nxt;
        end
    end

    // the pull is weak: enable stays high, an outside driver overrides
    assign watchdog_strobe_out_o = pull_hi_r;
    assign watchdog_strobe_oe_o  = 1'b1;
    assign strobe_open_o         = open_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_release;
        $fell(reset_o);
    endsequence

    sequence s_mr_taken;
        !lvl_r.mr_n && mr_deb_r && deb_cnt_r == DEB_LAST;
    endsequence

    property p_uv_reset;
        lvl_r.uv |=> reset_o && state_r == ST_SRC;
    endproperty
    a_uv_reset: assert property (p_uv_reset) else $error("undervoltage left reset off"); // RULE1

    property p_hold_len;
        s_release |-> $past(hold_cnt_r) == HOLD_LAST && $past(state_r) == ST_HOLD;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset released early"); // RULE2

    property p_mr_reset;
        s_mr_taken |=> !mr_deb_r ##1 reset_o;
    endproperty
    a_mr_reset: assert property (p_mr_reset) else $error("manual low gave no reset"); // RULE6

    property p_mr_glitch;
        mr_deb_r && !lvl_r.mr_n && deb_cnt_r != DEB_LAST |=> mr_deb_r;
    endproperty
    a_mr_glitch: assert property (p_mr_glitch) else $error("manual glitch accepted"); // RULE7

    property p_mr_release;
        $rose(mr_deb_r) && !lvl_r.uv |=> state_r == ST_HOLD && hold_cnt_r == '0;
    endproperty
    a_mr_release: assert property (p_mr_release) else $error("hold not started on release"); // RULE5

    property p_wd_timeout;
        state_r == ST_RUN && wd_cnt_r == WD_LAST && !stb_edge && !src_active
            |=> state_r == ST_HOLD ##1 reset_o;
    endproperty
    a_wd_timeout: assert property (p_wd_timeout) else $error("watchdog timeout missed"); // RULE8

    property p_wd_idle;
        reset_o |-> wd_cnt_r == '0;
    endproperty
    a_wd_idle: assert property (p_wd_idle) else $error("watchdog counted in reset"); // RULE9

    property p_wd_edge;
        state_r == ST_RUN && stb_edge && !src_active |=> wd_cnt_r == '0 && !reset_o;
    endproperty
    a_wd_edge: assert property (p_wd_edge) else $error("strobe edge did not restart"); // RULE10

    property p_pull_rise;
        $rose(watchdog_strobe_out_o) |-> pull_cnt_r == PULL_HI;
    endproperty
    a_pull_rise: assert property (p_pull_rise) else $error("pull high at wrong point"); // RULE12

    property p_pull_fall;
        !reset_o && $past(pull_cnt_r) == WD_LAST |-> !watchdog_strobe_out_o;
    endproperty
    a_pull_fall: assert property (p_pull_fall) else $error("pull pattern did not repeat"); // RULE13

    property p_pull_lock;
        !reset_o && stb_edge && !pull_self |=> pull_cnt_r == '0;
    endproperty
    a_pull_lock: assert property (p_pull_lock) else $error("pull phase not restarted"); // RULE14

    property p_complement;
        reset_o != reset_n_o;
    endproperty
    a_complement: assert property (p_complement) else $error("reset outputs not complementary"); // RULE17

endmodule : sswr_top

// ### testbench.sv
/*
 * self-checking bench for the supply supervisor, short counts
 * assumes the processor model drives or floats the strobe pin
 */
`timescale 1ns/10ps
module testbench
    import sswr_pkg::*;
;
    // ------------------------------------------------------------
    // harness
    // ------------------------------------------------------------
    localparam int HOLD = 50;
    localparam int WD   = 400;
    logic clk_i, arst_n_i, uv, mr_n, serve, drive, pin;
    logic str_out, str_oe, open, rst_n, rst;
    int   checked = 0;
    int   error_cnt = 0;
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    sswr_top #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD)) dut_u (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .undervolt_i(uv),
        .manual_reset_n_i(mr_n), .watchdog_strobe_in_i(pin),
        .watchdog_strobe_out_o(str_out), .watchdog_strobe_oe_o(str_oe),
        .strobe_open_o(open), .reset_n_o(rst_n), .reset_o(rst));
    sswr_proc_model #(.PER(100)) proc_u (
        .clk_i(clk_i), .serve_i(serve), .drive_i(drive),
        .pull_i(str_out), .pull_oe_i(str_oe), .pin_o(pin));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    // bounded wait for the reset output to reach a level
    task automatic wait_rst(input logic v, input int max, output int n);
        n = 0;
        while (rst !== v) begin
            step(1);
            n++;
            if (n > max) begin
                error_cnt++;
                $display("ERROR wait reset expected %0h seen %0h", v, rst);
                complete_run();
            end
        end
    endtask : wait_rst
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_powerup();
        int n;
        check("complement", rst_n, !rst);
        check("pull enable", str_oe, 1);
        wait_rst(1'b0, 200, n);
        check("power hold", n >= HOLD && n <= HOLD + 10, 1);
        check("complement", rst_n, !rst);
        $display("test powerup done");
    endtask : t_powerup
    task automatic t_uv();
        int n;
        step(10);
        uv = 1'b1;
        step(6);
        check("uv reset", rst, 1);
        step(100);
        check("uv lasting", rst, 1);
        uv = 1'b0;
        wait_rst(1'b0, 200, n);
        check("uv hold", n >= HOLD && n <= HOLD + 10, 1);
        $display("test undervoltage done");
    endtask : t_uv
    task automatic t_glitch();
        mr_n = 1'b0;
        step(5);
        mr_n = 1'b1;
        step(60);
        check("glitch", rst, 0);
        $display("test glitch done");
    endtask : t_glitch
    task automatic t_manual();
        int n;
        mr_n = 1'b0;
        step(50);
        check("manual reset", rst, 1);
        check("complement", rst_n, 0);
        mr_n = 1'b1;
        wait_rst(1'b0, 300, n);
        check("manual hold", n >= HOLD && n <= HOLD + 40, 1);
        $display("test manual done");
    endtask : t_manual
    // no strobe edges at all: timeout, hold, restart, then serviced
    task automatic t_wdog();
        int n;
        serve = 1'b0;
        mr_n = 1'b0;
        step(50);
        mr_n = 1'b1;
        wait_rst(1'b0, 300, n);
        wait_rst(1'b1, WD + 20, n);
        check("wd period", n >= WD && n <= WD + 6, 1);
        check("open while driven", open, 0);
        wait_rst(1'b0, 200, n);
        check("wd hold", n >= HOLD && n <= HOLD + 5, 1);
        wait_rst(1'b1, WD + 20, n);
        check("wd restart", n >= WD && n <= WD + 6, 1);
        wait_rst(1'b0, 200, n);
        serve = 1'b1;
        step(3 * WD);
        check("wd serviced", rst, 0);
        $display("test watchdog done");
    endtask : t_wdog
    // floating strobe: pull pattern keeps the watchdog serviced
    task automatic t_open();
        int hi;
        logic bad;
        hi = 0;
        bad = 1'b0;
        drive = 1'b0;
        repeat (2 * WD) begin
            step(1);
            hi += int'(str_out);
            bad |= rst;
        end
        check("pull high", hi, WD / 4);
        check("open no reset", bad, 0);
        check("open found", open, 1);
        $display("test open strobe done");
    endtask : t_open
    initial begin
        arst_n_i = 1'b0;
        uv = 1'b0;
        mr_n = 1'b1;
        serve = 1'b1;
        drive = 1'b1;
        repeat (20) @(posedge clk_i);
        #1 arst_n_i = 1'b1;
        t_powerup();
        t_uv();
        t_glitch();
        t_manual();
        t_wdog();
        t_open();
        complete_run();
    end
endmodule : testbench
